// [shared/cosdo_pkg.sv]
// Constants, field layouts and frame carriers for the CANopen SDO node core.
// Assumes a CAN controller outside that hands over whole received frames
// and accepts whole frames for transmission.
package cosdo_pkg;
  localparam logic [10:0] COSDO_RX_BASE = 11'h600;
  localparam logic [10:0] COSDO_TX_BASE = 11'h580;
  localparam logic [7:0] COSDO_CMD_WR16 = 8'h2B;
  localparam logic [7:0] COSDO_CMD_WR_ACK = 8'h60;
  localparam logic [7:0] COSDO_CMD_RD = 8'h40;
  localparam logic [7:0] COSDO_CMD_RD16 = 8'h4B;
  localparam logic [7:0] COSDO_CMD_ABORT = 8'h80;
  localparam logic [15:0] COSDO_IDX_CTRL = 16'h2100;
  localparam logic [15:0] COSDO_IDX_CTRLW = 16'h2101;
  localparam logic [15:0] COSDO_IDX_STAT = 16'h2000;
  localparam logic [15:0] COSDO_IDX_STATW = 16'h2001;
  localparam logic [7:0] COSDO_SUB_FIRST = 8'h03;
  localparam logic [7:0] COSDO_SUB_LAST = 8'h0F;
  localparam logic [7:0] COSDO_SUB_ZERO = 8'h00;
  localparam int COSDO_NVAL = 16;
  localparam logic [6:0] COSDO_MAX_ADDR = 7'h63;
  localparam logic [6:0] COSDO_TEN = 7'h0A;
  localparam logic [31:0] COSDO_ABORT_NOOBJ = 32'h06020000;
  localparam int COSDO_CLK_HZ = 100_000_000;
  localparam int COSDO_BLINK_MS = 200;
  localparam int COSDO_FLASH_MS = 200;
  localparam int COSDO_PAUSE_MS = 1000;
  localparam int COSDO_BLINK_CYC = COSDO_CLK_HZ / 1000 * COSDO_BLINK_MS;
  localparam int COSDO_FLASH_CYC = COSDO_CLK_HZ / 1000 * COSDO_FLASH_MS;
  localparam int COSDO_PAUSE_CYC = COSDO_CLK_HZ / 1000 * COSDO_PAUSE_MS;

  typedef enum logic [2:0]
  {
    COSDO_R1000K = 3'h0, COSDO_R800K = 3'h1, COSDO_R500K = 3'h2, COSDO_R250K = 3'h3,
    COSDO_R125K = 3'h4, COSDO_R100K = 3'h5, COSDO_R50K = 3'h6, COSDO_R20K = 3'h7
  } cosdo_rate_t;

  typedef enum logic [1:0]
  {
    COSDO_NMT_DOWN = 2'h0, COSDO_NMT_STOP = 2'h1, COSDO_NMT_PREOP = 2'h2,
    COSDO_NMT_OPER = 2'h3
  } cosdo_nmt_t;

  typedef struct packed
  {
    logic [10:0] cob_id;
    logic [3:0] dlc;
    logic [63:0] data;
  } cosdo_frame_t;
endpackage

// [core/cosdo_node.sv]
// CANopen SDO server with address and bit-rate selection and status LEDs.
// Assumes frames come from and go to a CAN controller in sys_clk domain;
// tx_ready is the controller's acceptance of the frame on tx_valid.
`timescale 1ns/100ps
module cosdo_node
  import cosdo_pkg::*;
#(
  parameter int BLINK_CYC = COSDO_BLINK_CYC,
  parameter int FLASH_CYC = COSDO_FLASH_CYC,
  parameter int PAUSE_CYC = COSDO_PAUSE_CYC
)
(
  input wire logic sys_clk,
  input wire logic rst,
  input wire logic [2:0] rate_code,
  input wire logic [3:0] addr_sw_high,
  input wire logic [3:0] addr_sw_low,
  input wire logic addr_sw_present,
  input wire logic [6:0] addr_param,
  input wire logic rx_valid,
  input wire cosdo_frame_t rx_frame,
  input wire logic rx_frame_error,
  output logic tx_valid,
  input wire logic tx_ready,
  output cosdo_frame_t tx_frame,
  input wire logic [COSDO_NVAL*16-1:0] return_values,
  input wire logic [15:0] state_word,
  output logic [COSDO_NVAL*16-1:0] set_values,
  output logic [15:0] control_word,
  output logic ctrl_write,
  input wire cosdo_nmt_t nmt_state,
  input wire logic bus_off,
  input wire logic drive_fault,
  output cosdo_rate_t bit_rate,
  output logic [6:0] node_addr,
  output logic addr_error,
  output logic run_led,
  output logic err_led
);
  // Boot latch: settings sampled once after reset release, then frozen
  logic booted;
  logic next_booted;
  cosdo_rate_t next_bit_rate;
  logic [6:0] next_node_addr;
  logic next_addr_error;
  logic [6:0] sw_value;

  always_comb
  begin
    sw_value = addr_sw_present ? COSDO_TEN * {3'h0, addr_sw_high} + {3'h0, addr_sw_low}
                               : 7'h00;
    next_booted = 1'b1;
    next_bit_rate = bit_rate;
    next_node_addr = node_addr;
    next_addr_error = addr_error;
    if (!booted)
    begin
      next_bit_rate = cosdo_rate_t'(rate_code);
      if (sw_value != 7'h00)
      begin
        next_node_addr = sw_value;
      end
      else
      begin
        next_node_addr = addr_param;
      end
      // Digits above nine or a zero address cannot be a valid node id
      next_addr_error = (addr_sw_present && (addr_sw_high > 4'h9 || addr_sw_low > 4'h9))
                        || (sw_value == 7'h00 && (addr_param == 7'h00
                        || addr_param > COSDO_MAX_ADDR));
    end
  end

  always_ff @(posedge sys_clk or posedge rst)
  begin
    if (rst)
    begin
      booted <= 1'b0;
      bit_rate <= COSDO_R1000K;
      node_addr <= 7'h00;
      addr_error <= 1'b0;
    end
    else
    begin
      booted <= next_booted;
      bit_rate <= next_bit_rate;
      node_addr <= next_node_addr;
      addr_error <= next_addr_error;
    end
  end

  // SDO server; one answer held until tx_ready, requests ignored meanwhile
  logic [7:0] rq_cmd;
  logic [15:0] rq_idx;
  logic [7:0] rq_sub;
  logic [15:0] rq_data;
  logic [15:0] rd_value;
  logic rq_hit;
  logic sub_ok;
  logic next_tx_valid;
  cosdo_frame_t next_tx_frame;
  logic [COSDO_NVAL*16-1:0] next_set_values;
  logic [15:0] next_control_word;
  logic next_ctrl_write;

  always_comb
  begin
    rq_cmd = rx_frame.data[7:0];
    rq_idx = rx_frame.data[23:8];
    rq_sub = rx_frame.data[31:24];
    rq_data = rx_frame.data[47:32];
    rq_hit = rx_valid && booted && !tx_valid
             && rx_frame.cob_id == COSDO_RX_BASE + {4'h0, node_addr};
    sub_ok = rq_sub >= COSDO_SUB_FIRST && rq_sub <= COSDO_SUB_LAST;
    // Return value n sits at slice n-1 of return_values, sub-index n+2
    rd_value = return_values[16*(rq_sub[3:0]-4'h3) +: 16];
    next_tx_valid = tx_valid && !tx_ready;
    next_tx_frame = tx_frame;
    next_set_values = set_values;
    next_control_word = control_word;
    next_ctrl_write = 1'b0;
    if (rq_hit)
    begin
      next_tx_valid = 1'b1;
      next_tx_frame.cob_id = COSDO_TX_BASE + {4'h0, node_addr};
      next_tx_frame.dlc = 4'h8;
      next_tx_frame.data = {COSDO_ABORT_NOOBJ, rq_sub, rq_idx, COSDO_CMD_ABORT};
      if (rq_cmd == COSDO_CMD_RD && rq_idx == COSDO_IDX_STAT && sub_ok)
      begin
        next_tx_frame.data = {16'h0000, rd_value, rq_sub, rq_idx, COSDO_CMD_RD16};
      end
      else if (rq_cmd == COSDO_CMD_RD && rq_idx == COSDO_IDX_STATW
               && rq_sub == COSDO_SUB_ZERO)
      begin
        next_tx_frame.data = {16'h0000, state_word, rq_sub, rq_idx, COSDO_CMD_RD16};
      end
      else if (rq_cmd == COSDO_CMD_WR16 && rq_idx == COSDO_IDX_CTRL && sub_ok)
      begin
        next_set_values[16*(rq_sub[3:0]-4'h3) +: 16] = rq_data;
        next_tx_frame.data = {32'h00000000, rq_sub, rq_idx, COSDO_CMD_WR_ACK};
      end
      else if (rq_cmd == COSDO_CMD_WR16 && rq_idx == COSDO_IDX_CTRLW
               && rq_sub == COSDO_SUB_ZERO)
      begin
        next_control_word = rq_data;
        next_ctrl_write = 1'b1;
        next_tx_frame.data = {32'h00000000, rq_sub, rq_idx, COSDO_CMD_WR_ACK};
      end
    end
  end

  always_ff @(posedge sys_clk or posedge rst)
  begin
    if (rst)
    begin
      tx_valid <= 1'b0;
      tx_frame <= '0;
      set_values <= '0;
      control_word <= 16'h0000;
      ctrl_write <= 1'b0;
    end
    else
    begin
      tx_valid <= next_tx_valid;
      tx_frame <= next_tx_frame;
      set_values <= next_set_values;
      control_word <= next_control_word;
      ctrl_write <= next_ctrl_write;
    end
  end

  // LED timing: one free-running blink phase and one flash sequencer per LED
  logic [31:0] blink_cnt;
  logic blink_phase;
  logic [31:0] next_blink_cnt;
  logic next_blink_phase;
  logic [31:0] flash_cnt [2];
  logic [31:0] next_flash_cnt [2];
  logic flash_req [2];
  logic flash_on [2];

  always_comb
  begin
    next_blink_cnt = blink_cnt + 32'h1;
    next_blink_phase = blink_phase;
    if (blink_cnt >= 32'(BLINK_CYC - 1))
    begin
      next_blink_cnt = 32'h0;
      next_blink_phase = !blink_phase;
    end
    flash_req[0] = nmt_state == COSDO_NMT_STOP;
    flash_req[1] = rx_frame_error;
  end

  genvar gi;
  generate
    for (gi = 0; gi < 2; gi++)
    begin : g_flash
      // Dark for PAUSE_CYC then flash for FLASH_CYC; stop state repeats it
      always_comb
      begin
        flash_on[gi] = flash_cnt[gi] != 32'h0 && flash_cnt[gi] <= 32'(FLASH_CYC);
        next_flash_cnt[gi] = flash_cnt[gi];
        if (flash_cnt[gi] != 32'h0)
        begin
          next_flash_cnt[gi] = flash_cnt[gi] - 32'h1;
        end
        else if (flash_req[gi])
        begin
          // Count ends at zero, so one less keeps the dark time at PAUSE_CYC
          next_flash_cnt[gi] = 32'(FLASH_CYC + PAUSE_CYC - 1);
        end
      end

      always_ff @(posedge sys_clk or posedge rst)
      begin
        if (rst)
        begin
          flash_cnt[gi] <= 32'h0;
        end
        else
        begin
          flash_cnt[gi] <= next_flash_cnt[gi];
        end
      end
    end
  endgenerate

  logic next_run_led;
  logic next_err_led;

  always_comb
  begin
    unique case (nmt_state)
      COSDO_NMT_DOWN: next_run_led = 1'b0;
      COSDO_NMT_STOP: next_run_led = flash_on[0];
      COSDO_NMT_PREOP: next_run_led = blink_phase;
      COSDO_NMT_OPER: next_run_led = 1'b1;
    endcase
    if (!booted)
    begin
      next_run_led = 1'b0;
    end
    if (bus_off || drive_fault)
    begin
      next_err_led = 1'b1;
    end
    else if (addr_error)
    begin
      next_err_led = blink_phase;
    end
    else
    begin
      next_err_led = flash_on[1];
    end
  end

  always_ff @(posedge sys_clk or posedge rst)
  begin
    if (rst)
    begin
      blink_cnt <= 32'h0;
      blink_phase <= 1'b0;
      run_led <= 1'b0;
      err_led <= 1'b0;
    end
    else
    begin
      blink_cnt <= next_blink_cnt;
      blink_phase <= next_blink_phase;
      run_led <= next_run_led;
      err_led <= next_err_led;
    end
  end
endmodule // cosdo_node

// [verification/cosdo_node_asserts.sv]
// Port-level checks for cosdo_node.
// Assumes one sys_clk domain and rst asynchronous, active high.
`timescale 1ns/100ps
module cosdo_node_asserts
  import cosdo_pkg::*;
(
  input wire logic sys_clk,
  input wire logic rst,
  input wire logic [2:0] rate_code,
  input wire logic rx_valid,
  input wire cosdo_frame_t rx_frame,
  input wire logic tx_valid,
  input wire logic tx_ready,
  input wire cosdo_frame_t tx_frame,
  input wire logic [15:0] control_word,
  input wire logic ctrl_write,
  input wire logic [COSDO_NVAL*16-1:0] return_values,
  input wire cosdo_nmt_t nmt_state,
  input wire logic bus_off,
  input wire logic drive_fault,
  input wire cosdo_rate_t bit_rate,
  input wire logic [6:0] node_addr,
  input wire logic run_led,
  input wire logic err_led
);
  default clocking @(posedge sys_clk); endclocking
  default disable iff (rst);
  logic up;
  always_ff @(posedge sys_clk or posedge rst)
    if (rst) up <= 1'b0;
    else up <= 1'b1;
  sequence s_take;
    rx_valid && up && !tx_valid && rx_frame.cob_id == COSDO_RX_BASE + 11'(node_addr);
  endsequence
  property p_answer; s_take |=> tx_valid; endproperty
  property p_txid; tx_valid |-> tx_frame.cob_id == COSDO_TX_BASE + 11'(node_addr)
    && tx_frame.dlc == 4'h8; endproperty
  property p_hold; tx_valid && !tx_ready |=> tx_valid && $stable(tx_frame); endproperty
  property p_drop; tx_valid && tx_ready |=> !tx_valid; endproperty
  property p_rd; s_take ##0 rx_frame.data[31:0] == 32'h0320_0040 |=>
    tx_frame.data == {16'h0000, $past(return_values[15:0]), 32'h0320_004B}; endproperty
  property p_cw; s_take ##0 rx_frame.data[31:0] == 32'h0021_012B |=>
    ctrl_write && control_word == $past(rx_frame.data[47:32]); endproperty
  property p_latch; up |=> $stable(node_addr) && $stable(bit_rate); endproperty
  property p_rate; $rose(up) |-> bit_rate == $past(rate_code); endproperty
  property p_oper; up && nmt_state == COSDO_NMT_OPER |=> run_led; endproperty
  property p_down; nmt_state == COSDO_NMT_DOWN |=> !run_led; endproperty
  property p_err; bus_off || drive_fault |=> err_led; endproperty
  a_answer: assert property (p_answer) else $error("request not answered");
  a_txid: assert property (p_txid) else $error("bad answer id");
  a_hold: assert property (p_hold) else $error("answer not held");
  a_drop: assert property (p_drop) else $error("answer kept after accept");
  a_rd: assert property (p_rd) else $error("bad status read");
  a_cw: assert property (p_cw) else $error("control word not written");
  a_latch: assert property (p_latch) else $error("setting changed while running");
  a_rate: assert property (p_rate) else $error("bad rate latch");
  a_oper: assert property (p_oper) else $error("run led off when operational");
  a_down: assert property (p_down) else $error("run led lit when down");
  a_err: assert property (p_err) else $error("error led off on fault");
endmodule // cosdo_node_asserts
bind cosdo_node cosdo_node_asserts u_cosdo_node_asserts (.sys_clk, .rst, .rate_code,
  .rx_valid, .rx_frame, .tx_valid, .tx_ready, .tx_frame, .control_word, .ctrl_write,
  .return_values, .nmt_state,
  .bus_off, .drive_fault, .bit_rate, .node_addr, .run_led, .err_led);

// [verification/cosdo_master.sv]
// CAN controller side: accepts answer frames after a set stall.
// Assumes tx_valid is held until accepted.
`timescale 1ns/100ps
module cosdo_master
(
  input wire logic sys_clk,
  input wire logic rst,
  input wire logic tx_valid,
  input wire logic [7:0] stall,
  output logic tx_ready
);
  logic [7:0] cnt;
  always_ff @(posedge sys_clk or posedge rst)
    if (rst) cnt <= 8'h00;
    else cnt <= (tx_valid && !tx_ready) ? cnt + 8'h01 : 8'h00;
  assign tx_ready = tx_valid && cnt >= stall;
endmodule // cosdo_master

// [verification/cosdo_node_tb.sv]
// Self-checking bench for cosdo_node with a stalling controller model.
// Assumes short LED timing parameters 4/4/8.
`timescale 1ns/100ps
module cosdo_node_tb
  import cosdo_pkg::*;
;
  logic sys_clk = 0, rst = 1, rx_valid = 0, rx_err = 0, pres = 0, bus_off = 0, fault = 0;
  logic [2:0] rate_code = 0;
  logic [3:0] hi = 0, lo = 0;
  logic [6:0] prm = 0, node_addr;
  logic [255:0] rv = 0, sv;
  logic [15:0] sw = 16'h0101, cw;
  logic [7:0] stall = 0;
  logic tx_valid, tx_ready, cwr, addr_error, run_led, err_led;
  cosdo_frame_t rx_frame = '0, tx_frame, f;
  cosdo_nmt_t nmt = COSDO_NMT_DOWN;
  cosdo_rate_t bit_rate;
  int error_cnt = 0, num_checks = 0, k, n;
  always #5 sys_clk = ~sys_clk;
  cosdo_node #(.BLINK_CYC(4), .FLASH_CYC(4), .PAUSE_CYC(8)) u_cosdo_node (.sys_clk, .rst,
    .rate_code, .addr_sw_high(hi), .addr_sw_low(lo), .addr_sw_present(pres),
    .addr_param(prm), .rx_valid, .rx_frame, .rx_frame_error(rx_err), .tx_valid, .tx_ready,
    .tx_frame, .return_values(rv), .state_word(sw), .set_values(sv), .control_word(cw),
    .ctrl_write(cwr), .nmt_state(nmt), .bus_off, .drive_fault(fault), .bit_rate,
    .node_addr, .addr_error, .run_led, .err_led);
  cosdo_master u_cosdo_master (.sys_clk, .rst, .tx_valid, .stall, .tx_ready);
  task automatic finish_test();
    if (error_cnt == 0 && num_checks > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask
  task automatic chk(input logic [78:0] seen, input logic [78:0] exp);
    num_checks++;
    if (seen !== exp)
    begin
      error_cnt++;
      $display("CHECK FAILED t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  task automatic boot(input logic [2:0] r, input logic [3:0] h, l, input logic p,
    input logic [6:0] a);
    @(negedge sys_clk);
    rst = 1;
    {rate_code, hi, lo, pres, prm} = {r, h, l, p, a};
    repeat (2) @(negedge sys_clk);
    rst = 0;
    repeat (2) @(negedge sys_clk);
  endtask
  // Byte0 command, index low byte first, sub-index, value low byte first
  function automatic logic [63:0] req(logic [7:0] c, logic [15:0] i, logic [7:0] s,
    logic [15:0] v);
    return {16'h0000, v, s, i, c};
  endfunction
  task automatic sdo(input logic [10:0] id, input logic [63:0] d, input bit want);
    int i;
    @(negedge sys_clk);
    rx_frame = '{id, 4'h8, d};
    rx_valid = 1;
    @(negedge sys_clk);
    rx_valid = 0;
    rx_frame = ~rx_frame;
    for (i = 0; i < 20 && !(tx_valid && tx_ready); i++) @(negedge sys_clk);
    f = (i < 20) ? tx_frame : '0;
    if (want && i == 20)
    begin
      error_cnt++;
      finish_test();
    end
  endtask
  task automatic lit(input int cyc, input int exp, input bit run);
    n = 0;
    repeat (cyc) @(negedge sys_clk) n += run ? run_led : err_led;
    chk(n, exp);
  endtask
  initial
  begin
    #100000;
    error_cnt++;
    finish_test();
  end
  initial
  begin
    for (k = 0; k < 8; k++)
    begin
      boot(3'(k), 4'(k), 4'(9 - k), 1, 7'h01);
      chk(bit_rate, k);
      chk(node_addr, 9 * k + 9);
    end
    {hi, rate_code} = 7'h10;
    repeat (3) @(negedge sys_clk);
    chk({bit_rate, node_addr}, {3'h7, 7'd72});
    boot(2, 0, 0, 1, 7'h2A);
    chk(node_addr, 7'h2A);
    boot(2, 5, 5, 0, 7'h15);
    chk(node_addr, 7'h15);
    boot(3, 0, 3, 1, 7'h01);
    rv[15:0] = 16'h1388;
    rv[207:192] = 16'hBEEF;
    sdo(11'h603, req(8'h2B, 16'h2100, 8'h03, 16'h1388), 1);
    chk(f, {11'h583, 4'h8, req(8'h60, 16'h2100, 8'h03, 0)});
    chk(sv[15:0], 16'h1388);
    // Let the stall-free answer be taken before the model starts stalling
    @(negedge sys_clk);
    stall = 3;
    sdo(11'h603, req(8'h40, 16'h2000, 8'h03, 0), 1);
    chk(f, {11'h583, 4'h8, 64'h0000_1388_0320_004B});
    sdo(11'h603, req(8'h40, 16'h2000, 8'h0F, 0), 1);
    chk(f.data, req(8'h4B, 16'h2000, 8'h0F, 16'hBEEF));
    sdo(11'h603, req(8'h40, 16'h2001, 8'h00, 0), 1);
    chk(f.data, req(8'h4B, 16'h2001, 8'h00, 16'h0101));
    sdo(11'h603, req(8'h2B, 16'h2101, 8'h00, 16'h0001), 1);
    chk(cw, 16'h0001);
    sdo(11'h603, req(8'h40, 16'h2000, 8'h01, 0), 1);
    chk(f.data, {32'h0602_0000, 32'h0120_0080});
    sdo(11'h604, req(8'h40, 16'h2000, 8'h03, 0), 0);
    chk(f, '0);
    nmt = COSDO_NMT_OPER;
    lit(8, 8, 1);
    nmt = COSDO_NMT_PREOP;
    repeat (2) @(negedge sys_clk);
    lit(24, 12, 1);
    nmt = COSDO_NMT_STOP;
    repeat (2) @(negedge sys_clk);
    lit(24, 8, 1);
    nmt = COSDO_NMT_DOWN;
    lit(4, 0, 1);
    rx_err = 1;
    @(negedge sys_clk);
    rx_err = 0;
    lit(20, 4, 0);
    bus_off = 1;
    lit(4, 4, 0);
    {bus_off, fault} = 2'h1;
    lit(4, 4, 0);
    fault = 0;
    boot(0, 4'hA, 0, 1, 7'h01);
    chk(addr_error, 1);
    lit(24, 12, 0);
    finish_test();
  end
endmodule // cosdo_node_tb
